//--- core/i2c_flags_pkg.sv
// Constants shared by the interrupt status flag logic.
package i2c_flags_pkg;
  localparam int STAT_W = 16;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int LVL_W = 6;
  localparam int CAUSE_W = 16;
  localparam int ACTIVITY_BIT = 8;
  localparam int TX_DONE_BIT = 7;
  localparam int ABORT_BIT = 6;
  localparam int READ_REQ_BIT = 5;
  localparam int TX_EMPTY_BIT = 4;
  localparam logic [STAT_W-1:0] STATUS_RESET = 16'h0000;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 16'h0000;
  localparam logic [LVL_W-1:0] LEVEL_RESET = 6'h00;
  localparam logic [LVL_W-1:0] LEVEL_FULL = 6'h20;
endpackage : i2c_flags_pkg

//--- core/i2c_interrupt_status_flags.sv
// Transmit FIFO and the five interrupt status flags of the two-wire controller.
//
// Summary of operation
// R1 - Activity flag clears on reading activity clear, combined clear, or reset.
// R2 - Disabling the controller also clears the activity flag at bit 8.
// R3 - Activity flag stays set after idle until a clearing method acts.
// R4 - Slave transmitter sets bit 7 when the master does not acknowledge.
// R5 - Transmit abort sets bit 6 when transmit FIFO contents cannot complete.
// R6 - Cause of each abort is recorded in a readable abort cause register.
// R7 - While abort is set the FIFO stays flushed until abort clear is read.
// R8 - A remote master reading this slave sets the read request flag, bit 5.
// R9 - Serial clock is held low until the read request is serviced.
// R10 - Host answers a read request by writing the byte to the data register.
// R11 - Read request flag drops right after its clear register is read.
// R12 - Transmit empty flag, bit 4, is set while level is at or below threshold.
// R13 - Transmit empty clears by itself once level rises above the threshold.
// R14 - Disabled: FIFO flushed; transmit empty follows bus activity.
// R15 - Each mask bit gates its flag into the status view.
// R16 - Status is read only and every flag reads zero after reset.
////////////////////////////////////////////////////////////////////////////////
module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int LW = 6
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [LW-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;
  logic [LW-1:0] next_level;

  // Writes and reads are dropped while the FIFO is being flushed.
  assign push = in_valid & in_ready & ~flush;
  assign pop = out_valid & out_ready & ~flush;
  assign out_data = mem[rd_ptr];

  // Next fill level; a flush empties the FIFO at once.
  always_comb begin
    next_level = level;
    if (flush) begin
      next_level = '0;
    end else if (push & ~pop) begin
      next_level = level + LW'(1);
    end else if (pop & ~push) begin
      next_level = level - LW'(1);
    end
  end

  // Pointers, level and registered handshake flags.
  always_ff @(posedge mclk) begin
    if (!rst_b || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      level <= next_level;
      in_ready <= next_level != LW'(DEPTH);
      out_valid <= next_level != '0;
    end
  end

  // Storage array.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : tx_fifo
////////////////////////////////////////////////////////////////////////////////
module i2c_interrupt_status_flags (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic controller_enabled,
  input wire logic [i2c_flags_pkg::STAT_W-1:0] intr_mask,
  input wire logic [i2c_flags_pkg::LVL_W-1:0] tx_threshold_reg,
  input wire logic activity_clear_reg_rd,
  input wire logic combined_interrupt_clear_reg_rd,
  input wire logic abort_clear_reg_rd,
  input wire logic read_request_clear_reg_rd,
  input wire logic bus_active,
  input wire logic slave_tx_nack,
  input wire logic abort_event,
  input wire logic [i2c_flags_pkg::CAUSE_W-1:0] abort_cause_in,
  input wire logic read_request_event,
  input wire logic data_cmd_valid,
  output logic data_cmd_ready,
  input wire logic [i2c_flags_pkg::DATA_W-1:0] data_cmd_byte,
  output logic tx_byte_valid,
  input wire logic tx_byte_ready,
  output logic [i2c_flags_pkg::DATA_W-1:0] tx_byte,
  output logic [i2c_flags_pkg::LVL_W-1:0] tx_fifo_level,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  output logic [i2c_flags_pkg::STAT_W-1:0] interrupt_status,
  output logic [i2c_flags_pkg::CAUSE_W-1:0] abort_cause_reg
);
  import i2c_flags_pkg::*;
  logic activity_flag;
  logic tx_done_flag;
  logic transmit_abort_flag;
  logic read_request_flag;
  logic tx_empty_flag;
  logic stretch_pend;
  logic scl_meta;
  logic scl_sync;
  logic fifo_flush;

  // Set wins over clear so an event in the clearing cycle is kept.
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    return set | (cur & ~clr);
  endfunction : sticky
  // Disabled controller or a pending abort keeps the FIFO flushed.
  assign fifo_flush = transmit_abort_flag | ~controller_enabled; // R7 R14

  tx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .LW(LVL_W)) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .flush(fifo_flush),
    .in_valid(data_cmd_valid),
    .in_ready(data_cmd_ready),
    .in_data(data_cmd_byte),
    .out_valid(tx_byte_valid),
    .out_ready(tx_byte_ready),
    .out_data(tx_byte),
    .level(tx_fifo_level)
  );

  // Two-flop synchroniser for the serial clock pin.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
    end
  end

  // Sticky activity flag with its four ways of clearing.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      activity_flag <= 1'b0; // R1 R16
    end else begin
      activity_flag <= sticky(activity_flag, bus_active, activity_clear_reg_rd
        | combined_interrupt_clear_reg_rd | ~controller_enabled); // R1 R2 R3
    end
  end

  // Slave transmit done on a missing acknowledge.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tx_done_flag <= 1'b0;
    end else begin
      tx_done_flag <= sticky(tx_done_flag, slave_tx_nack, combined_interrupt_clear_reg_rd); // R4
    end
  end

  // Transmit abort flag and its accumulated cause.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      transmit_abort_flag <= 1'b0;
      abort_cause_reg <= CAUSE_RESET;
    end else begin
      transmit_abort_flag <= sticky(transmit_abort_flag, abort_event,
        abort_clear_reg_rd | combined_interrupt_clear_reg_rd); // R5 R7
      if (abort_event) begin
        abort_cause_reg <= abort_cause_in | (transmit_abort_flag ? abort_cause_reg : '0); // R6
      end else if (abort_clear_reg_rd | combined_interrupt_clear_reg_rd) begin
        abort_cause_reg <= CAUSE_RESET;
      end
    end
  end

  // Read request flag.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      read_request_flag <= 1'b0;
    end else begin
      read_request_flag <= sticky(read_request_flag, read_request_event,
        read_request_clear_reg_rd | combined_interrupt_clear_reg_rd); // R8 R11
    end
  end

  // Clock stretch: hold SCL low from its low phase until a byte is written.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      stretch_pend <= 1'b0;
      scl_oe <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      if (read_request_event) begin
        stretch_pend <= 1'b1;
      end else if (tx_fifo_level != '0 || !controller_enabled) begin
        stretch_pend <= 1'b0; // R10
      end
      if (stretch_pend && tx_fifo_level == '0 && controller_enabled) begin
        scl_oe <= scl_oe | ~scl_sync; // R9
      end else begin
        scl_oe <= 1'b0;
      end
    end
  end

  // Level-driven transmit empty flag, no software clear.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tx_empty_flag <= 1'b0;
    end else if (!controller_enabled) begin
      tx_empty_flag <= bus_active; // R14
    end else begin
      tx_empty_flag <= tx_fifo_level <= tx_threshold_reg; // R12 R13
    end
  end

  // Masked, read-only status view; unlisted bits read zero.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      interrupt_status <= STATUS_RESET; // R16
    end else begin
      interrupt_status <= STATUS_RESET;
      interrupt_status[ACTIVITY_BIT] <= activity_flag & intr_mask[ACTIVITY_BIT]; // R15
      interrupt_status[TX_DONE_BIT] <= tx_done_flag & intr_mask[TX_DONE_BIT];
      interrupt_status[ABORT_BIT] <= transmit_abort_flag & intr_mask[ABORT_BIT];
      interrupt_status[READ_REQ_BIT] <= read_request_flag & intr_mask[READ_REQ_BIT];
      interrupt_status[TX_EMPTY_BIT] <= tx_empty_flag & intr_mask[TX_EMPTY_BIT];
    end
  end

  AST_ACT_CLR: assert property (@(posedge mclk) disable iff (!rst_b) // R1
    (activity_clear_reg_rd | combined_interrupt_clear_reg_rd) && !bus_active |=> !activity_flag)
    else $error("activity flag not cleared by read");
  AST_ACT_DIS: assert property (@(posedge mclk) disable iff (!rst_b) // R2
    !controller_enabled && !bus_active |=> !activity_flag)
    else $error("activity flag not cleared by disable");
  AST_ACT_HOLD: assert property (@(posedge mclk) disable iff (!rst_b) // R3
    activity_flag && controller_enabled && !activity_clear_reg_rd
      && !combined_interrupt_clear_reg_rd |=> activity_flag)
    else $error("activity flag dropped without a clear");
  AST_DONE: assert property (@(posedge mclk) disable iff (!rst_b) // R4
    slave_tx_nack |=> tx_done_flag ##1 interrupt_status[TX_DONE_BIT] == $past(intr_mask[TX_DONE_BIT]))
    else $error("transmit done not set on nack");
  AST_ABORT: assert property (@(posedge mclk) disable iff (!rst_b) // R5
    abort_event |=> transmit_abort_flag)
    else $error("abort flag not set");
  AST_CAUSE: assert property (@(posedge mclk) disable iff (!rst_b) // R6
    abort_event |=> (abort_cause_reg & $past(abort_cause_in)) == $past(abort_cause_in))
    else $error("abort cause not recorded");
  AST_FLUSH: assert property (@(posedge mclk) disable iff (!rst_b) // R7
    transmit_abort_flag |=> tx_fifo_level == '0 && !tx_byte_valid)
    else $error("fifo not flushed during abort");
  AST_RDREQ: assert property (@(posedge mclk) disable iff (!rst_b) // R8
    read_request_event |=> read_request_flag)
    else $error("read request flag not set");
  AST_STRETCH: assert property (@(posedge mclk) disable iff (!rst_b) // R9
    stretch_pend && tx_fifo_level == '0 && controller_enabled && !scl_sync
      && !read_request_event ##1 tx_fifo_level == '0 && controller_enabled |=> scl_oe)
    else $error("serial clock not held low");
  AST_RDCLR: assert property (@(posedge mclk) disable iff (!rst_b) // R11
    read_request_clear_reg_rd && !read_request_event |=> !read_request_flag)
    else $error("read request flag not cleared");
  AST_TXE: assert property (@(posedge mclk) disable iff (!rst_b) // R12
    controller_enabled && tx_fifo_level <= tx_threshold_reg |=> tx_empty_flag)
    else $error("transmit empty not set");
  AST_TXE_CLR: assert property (@(posedge mclk) disable iff (!rst_b) // R13
    controller_enabled && tx_fifo_level > tx_threshold_reg |=> !tx_empty_flag)
    else $error("transmit empty not cleared");
  AST_TXE_DIS: assert property (@(posedge mclk) disable iff (!rst_b) // R14
    !controller_enabled |=> tx_empty_flag == $past(bus_active) && tx_fifo_level == '0)
    else $error("disabled transmit empty wrong");
  AST_MASK: assert property (@(posedge mclk) disable iff (!rst_b) // R15
    1'b1 |=> interrupt_status[ABORT_BIT] == $past(transmit_abort_flag & intr_mask[ABORT_BIT]))
    else $error("mask does not gate status");
  AST_RESV: assert property (@(posedge mclk) disable iff (!rst_b) // R16
    interrupt_status[15:9] == '0 && interrupt_status[3:0] == '0)
    else $error("unused status bits not zero");
endmodule : i2c_interrupt_status_flags

//--- tb/remote_bus_model.sv
// Behavioural remote bus device: serial clock, slave events and FIFO pops.
module remote_bus_model (
  input wire logic mclk,
  input wire logic scl_oe,
  input wire logic tx_byte_valid,
  input wire logic [i2c_flags_pkg::DATA_W-1:0] tx_byte,
  output logic scl_in,
  output logic bus_active = 1'b0,
  output logic read_request_event = 1'b0,
  output logic slave_tx_nack = 1'b0,
  output logic tx_byte_ready = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  import i2c_flags_pkg::*;
  logic scl_drv = 1'b1;
  logic pop_en = 1'b0;
  logic [DATA_W-1:0] got [$];
  // Serial clock toggles only within a frame and idles high on the pull-up.
  always begin
    #100;
    scl_drv = bus_active ? ~scl_drv : 1'b1;
  end
  // Open-drain wire: the controller pulls the line low while it stretches.
  assign scl_in = scl_drv & ~scl_oe;
  // Pops every other cycle so the FIFO sees a stalling reader.
  always @(posedge mclk) begin
    if (tx_byte_ready && tx_byte_valid) got.push_back(tx_byte);
    #2 tx_byte_ready = pop_en && tx_byte_valid && !tx_byte_ready;
  end
  // Addresses the controller for a read.
  task rd_req();
    bus_active = 1'b1;
    read_request_event = 1'b1;
    @(posedge mclk) #2;
    read_request_event = 1'b0;
  endtask : rd_req
  // Leaves the last byte unacknowledged and ends the frame.
  task nack();
    slave_tx_nack = 1'b1;
    @(posedge mclk) #2;
    slave_tx_nack = 1'b0;
    bus_active = 1'b0;
  endtask : nack
endmodule : remote_bus_model

//--- tb/tb_i2c_interrupt_status_flags.sv
// Self-checking bench for the interrupt status flag block.
module tb_i2c_interrupt_status_flags;
  timeunit 1ns;
  timeprecision 100ps;
  import i2c_flags_pkg::*;
  logic mclk = 1'b0, rst_b = 1'b0, controller_enabled = 1'b1;
  logic [STAT_W-1:0] intr_mask = 16'hffff;
  logic [LVL_W-1:0] tx_threshold_reg = 6'h02;
  logic activity_clear_reg_rd = 1'b0, combined_interrupt_clear_reg_rd = 1'b0;
  logic abort_clear_reg_rd = 1'b0, read_request_clear_reg_rd = 1'b0, abort_event = 1'b0;
  logic [CAUSE_W-1:0] abort_cause_in = 16'h0000;
  logic data_cmd_valid = 1'b0, data_cmd_ready, tx_byte_valid, tx_byte_ready;
  logic scl_in, scl_out, scl_oe, bus_active, slave_tx_nack, read_request_event;
  logic [DATA_W-1:0] data_cmd_byte = 8'h00, tx_byte;
  logic [LVL_W-1:0] tx_fifo_level;
  logic [STAT_W-1:0] interrupt_status;
  logic [CAUSE_W-1:0] abort_cause_reg;
  int error_cnt = 0, n_checks = 0;

  i2c_interrupt_status_flags i2c_interrupt_status_flags_i (.mclk, .rst_b, .controller_enabled,
    .intr_mask, .tx_threshold_reg, .activity_clear_reg_rd, .combined_interrupt_clear_reg_rd,
    .abort_clear_reg_rd, .read_request_clear_reg_rd, .bus_active, .slave_tx_nack,
    .abort_event, .abort_cause_in, .read_request_event, .data_cmd_valid, .data_cmd_ready,
    .data_cmd_byte, .tx_byte_valid, .tx_byte_ready, .tx_byte, .tx_fifo_level, .scl_in,
    .scl_out, .scl_oe, .interrupt_status, .abort_cause_reg);
  remote_bus_model remote_bus_model_i (.mclk, .scl_oe, .tx_byte_valid, .tx_byte, .scl_in,
    .bus_active, .read_request_event, .slave_tx_nack, .tx_byte_ready);

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running system clock.
  always #12.5 mclk = ~mclk;
  // Steps past n edges and lands just after the last one.
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick
  // Raises a one-cycle pulse.
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse
  // Compares and counts.
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Writes one byte into the data path once it is accepted.
  task wr(input logic [7:0] b);
    int n;
    n = 0;
    data_cmd_byte = b;
    data_cmd_valid = 1'b1;
    while (data_cmd_ready !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    chk(data_cmd_ready, 1'b1);
    tick(1);
    data_cmd_valid = 1'b0;
    tick(1);
  endtask : wr
  // Prints the counts and the verdict, then ends the run.
  task summarize();
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  // Cuts a hang short.
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence.
  initial begin
    tick(4);
    chk(interrupt_status, STATUS_RESET);
    chk(abort_cause_reg, CAUSE_RESET);
    chk({data_cmd_ready, tx_byte_valid, scl_oe, tx_fifo_level}, 16'h0000);
    rst_b = 1'b1;
    $display("test reset done");
    wr(8'h00);
    wr(8'h01);
    tick(3);
    chk(interrupt_status[4], 1);
    wr(8'h02);
    tick(3);
    chk(interrupt_status[4], 0);
    for (int i = 3; i < 40 && data_cmd_ready === 1'b1; i++) wr(i[7:0]);
    chk(tx_fifo_level, LEVEL_FULL);
    chk(data_cmd_ready, 0);
    remote_bus_model_i.pop_en = 1'b1;
    for (int n = 0; n < 200 && tx_fifo_level !== LEVEL_RESET; n++) tick(1);
    tick(3);
    remote_bus_model_i.pop_en = 1'b0;
    chk(remote_bus_model_i.got.size(), FIFO_DEPTH);
    for (int i = 0; i < FIFO_DEPTH; i++) chk(remote_bus_model_i.got[i], i[7:0]);
    $display("test fifo done");
    wr(8'h11);
    wr(8'h22);
    abort_cause_in = 16'h0005;
    pulse(abort_event);
    tick(3);
    chk(interrupt_status[6], 1);
    chk(abort_cause_reg, 16'h0005);
    chk(tx_fifo_level, 0);
    chk(data_cmd_ready, 0);
    intr_mask[6] = 1'b0;
    tick(2);
    chk(interrupt_status[6], 0);
    intr_mask[6] = 1'b1;
    pulse(abort_clear_reg_rd);
    tick(3);
    chk(interrupt_status[6], 0);
    chk(abort_cause_reg, 0);
    chk(data_cmd_ready, 1);
    $display("test abort done");
    for (int m = 0; m < 3; m++) begin
      remote_bus_model_i.bus_active = 1'b1;
      tick(3);
      remote_bus_model_i.bus_active = 1'b0;
      tick(10);
      chk(interrupt_status[8], 1);
      if (m == 0) pulse(activity_clear_reg_rd);
      else if (m == 1) pulse(combined_interrupt_clear_reg_rd);
      else begin
        controller_enabled = 1'b0;
        tick(2);
        controller_enabled = 1'b1;
      end
      tick(3);
      chk(interrupt_status[8], 0);
    end
    $display("test activity done");
    controller_enabled = 1'b0;
    remote_bus_model_i.bus_active = 1'b1;
    tick(4);
    chk(interrupt_status[4], 1);
    chk(data_cmd_ready, 0);
    remote_bus_model_i.bus_active = 1'b0;
    tick(4);
    chk(interrupt_status[4], 0);
    controller_enabled = 1'b1;
    tick(3);
    $display("test disabled done");
    remote_bus_model_i.rd_req();
    for (int n = 0; n < 40 && scl_oe !== 1'b1; n++) tick(1);
    chk(scl_oe, 1);
    chk(scl_in, 0);
    chk(scl_out, 0);
    chk(interrupt_status[5], 1);
    wr(8'ha5);
    tick(2);
    chk(scl_oe, 0);
    pulse(read_request_clear_reg_rd);
    tick(3);
    chk(interrupt_status[5], 0);
    remote_bus_model_i.pop_en = 1'b1;
    tick(4);
    chk(remote_bus_model_i.got[FIFO_DEPTH], 8'ha5);
    remote_bus_model_i.nack();
    tick(3);
    chk(interrupt_status[7], 1);
    pulse(combined_interrupt_clear_reg_rd);
    tick(3);
    chk(interrupt_status[8:5], 0);
    $display("test read request done");
    summarize();
  end
endmodule : tb_i2c_interrupt_status_flags
